// [dv/motor_start_stop_sequencer_tb.sv]
`timescale 1ns/1ps
`include "mss_consts.vh"
module motor_start_stop_sequencer_tb;
   logic        clk, sys_rst, reg_wr, reg_rd;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata, rv;
   wire  [15:0] reg_rdata, out_freq, dc_brake_cur, speed;
   wire         out_enable, dc_brake_on, sc_brake_on, running, sleeping;
   int          err_count, num_checks, n;

   mss_seq #(.TICK_CYC(4)) u_mss_seq (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .out_freq(out_freq), .out_enable(out_enable), .dc_brake_on(dc_brake_on),
      .dc_brake_cur(dc_brake_cur), .sc_brake_on(sc_brake_on), .running(running), .sleeping(sleeping));
   mss_motor_model u_mss_motor_model (.clk(clk), .sys_rst(sys_rst), .out_freq(out_freq),
      .out_enable(out_enable), .dc_brake_on(dc_brake_on), .sc_brake_on(sc_brake_on), .speed(speed));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic [15:0] probe(input int s);
      case (s)
         0: probe = {15'h0000, out_enable};
         1: probe = out_freq;
         2: probe = {15'h0000, running};
         3: probe = {15'h0000, dc_brake_on};
         4: probe = {15'h0000, sc_brake_on};
         default: probe = {15'h0000, sleeping};
      endcase
   endfunction
   // waits, bounded, until probe s equals v (want=1) or leaves v (want=0)
   task automatic wait_for(input int s, input logic [15:0] v, input bit want, output int k);
      k = 0;
      while (((probe(s) === v) != want) && k < 400) begin
         @(posedge clk);
         #1 k++;
      end
      if (k >= 400)
         err_count++;
   endtask

   task automatic t_defaults;
      rd(`MSS_A_INIT_FREQ, rv);
      chk("init_freq", rv, `MSS_RST_INIT_FREQ);
      rd(`MSS_A_STOP_SPEED, rv);
      chk("stop_speed", rv, `MSS_RST_STOP_SPEED);
      rd(`MSS_A_BELOW_ACT, rv);
      chk("below_act", rv, {8'h00, `MSS_RST_BELOW_ACT});
      rd(4'hE, rv);
      chk("unmapped", rv, 16'h0000);
      wr(`MSS_A_INIT_FREQ, 16'hFFFF);
      rd(`MSS_A_INIT_FREQ, rv);
      chk("init_clamp", rv, `MSS_MAX_INIT_FREQ);
      wr(`MSS_A_INIT_FREQ, 16'h0032);
      $display("t_defaults done");
   endtask
   // direct start, hold, ramp, then ramped stop; lower limit sits above start freq
   task automatic t_direct;
      wr(`MSS_A_LOWER_LIM, 16'h0040);
      wr(`MSS_A_SET_FREQ, 16'h0100);
      wr(`MSS_A_RAMP_STEP, 16'h0010);
      wr(`MSS_A_HOLD_TIME, 16'h0001);
      wr(`MSS_A_CTRL, 16'h0004);
      wait_for(0, 16'h0001, 1, n);
      chk("first_freq", out_freq, 16'h0032);
      wait_for(1, 16'h0032, 0, n);
      chk("hold_len", 16'(n >= 36 && n <= 46), 16'h0001);
      wait_for(1, 16'h0100, 1, n);
      chk("ramp_top", out_freq, 16'h0100);
      wr(`MSS_A_CTRL, 16'h0000);
      repeat (5) @(posedge clk);
      #1 chk("decel_drop", 16'(out_enable && out_freq < 16'h0100), 16'h0001);
      wait_for(2, 16'h0000, 1, n);
      chk("decel_end", 16'(n < 40 && out_freq == 16'h0000), 16'h0001);
      wr(`MSS_A_HOLD_TIME, 16'h0000);
      $display("t_direct done");
   endtask
   // short-circuit start, then coast stop
   task automatic t_coast;
      wr(`MSS_A_SC_HOLD, 16'h0001);
      wr(`MSS_A_CTRL, 16'h0004);
      wait_for(4, 16'h0001, 1, n);
      chk("sc_brake", {15'h0000, sc_brake_on}, 16'h0001);
      wait_for(1, 16'h0100, 1, n);
      wr(`MSS_A_CTRL, 16'h0002);
      repeat (3) @(posedge clk);
      #1 chk("coast_cut", out_freq, 16'h0000);
      chk("coast_off", {15'h0000, out_enable}, 16'h0000);
      chk("load_coasts", 16'(speed != 16'h0000), 16'h0001);
      wr(`MSS_A_SC_HOLD, 16'h0000);
      wait_for(2, 16'h0000, 1, n);
      $display("t_coast done");
   endtask
   // braked start with current scaling, then zero braking time
   task automatic t_dcbrake;
      wr(`MSS_A_BRK_CUR, 16'h01F4);
      wr(`MSS_A_BRK_TIME, 16'h0002);
      wr(`MSS_A_CTRL, 16'h0005);
      wait_for(3, 16'h0001, 1, n);
      chk("brake_cur", dc_brake_cur, 16'h01F4);
      wait_for(3, 16'h0001, 0, n);
      chk("brake_len", 16'(n >= 6 && n <= 12), 16'h0001);
      wait_for(0, 16'h0001, 1, n);
      chk("after_brake", {15'h0000, out_enable}, 16'h0001);
      wr(`MSS_A_CTRL, 16'h0003);
      wait_for(2, 16'h0000, 1, n);
      wr(`MSS_A_BRK_TIME, 16'h0000);
      wr(`MSS_A_CTRL, 16'h0007);
      wait_for(0, 16'h0001, 1, n);
      chk("no_brake", {15'h0000, dc_brake_on}, 16'h0000);
      chk("no_brake_freq", out_freq, 16'h0032);
      wr(`MSS_A_CTRL, 16'h0003);
      wait_for(2, 16'h0000, 1, n);
      $display("t_dcbrake done");
   endtask
   // set frequency below start frequency, then start delay with abort
   task automatic t_standby_delay;
      wr(`MSS_A_SET_FREQ, 16'h0010);
      wr(`MSS_A_CTRL, 16'h0004);
      repeat (20) @(posedge clk);
      #1 chk("standby", {15'h0000, running}, 16'h0000);
      wr(`MSS_A_CTRL, 16'h0000);
      wr(`MSS_A_SET_FREQ, 16'h0100);
      wr(`MSS_A_START_DLY, 16'h0001);
      wr(`MSS_A_CTRL, 16'h0004);
      repeat (20) @(posedge clk);
      #1 chk("in_delay", {14'h0000, running, out_enable}, 16'h0002);
      rd(`MSS_A_STATUS, rv);
      chk("delay_state", rv, 16'h0001);
      wr(`MSS_A_CTRL, 16'h0000);
      repeat (3) @(posedge clk);
      #1 chk("abort", {15'h0000, running}, 16'h0000);
      wr(`MSS_A_START_DLY, 16'h0000);
      $display("t_standby_delay done");
   endtask
   // set frequency falls below the lower limit with sleep selected
   task automatic t_sleep;
      wr(`MSS_A_BELOW_ACT, 16'h0002);
      wr(`MSS_A_CTRL, 16'h0004);
      wait_for(1, 16'h0100, 1, n);
      wr(`MSS_A_SET_FREQ, 16'h0020);
      wait_for(5, 16'h0001, 1, n);
      chk("sleep", {14'h0000, sleeping, out_enable}, 16'h0002);
      $display("t_sleep done");
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // watchdog well past the expected run length
   initial begin
      #500000;
      err_count++;
      test_done;
   end
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_defaults;
      t_direct;
      t_coast;
      t_dcbrake;
      t_standby_delay;
      t_sleep;
      test_done;
   end
endmodule // motor_start_stop_sequencer_tb

// [dv/mss_motor_model.sv]
`timescale 1ns/1ps
// motor load: follows the drive frequency, coasts down when the output is cut
module mss_motor_model (
   input wire          clk,
   input wire          sys_rst,
   input wire [15:0]   out_freq,
   input wire          out_enable,
   input wire          dc_brake_on,
   input wire          sc_brake_on,
   output logic [15:0] speed
);
   // braking holds the shaft, drive sets speed, otherwise inertia
   always @(posedge clk) begin
      if (sys_rst || dc_brake_on || sc_brake_on)
         speed <= 16'h0000;
      else if (out_enable)
         speed <= out_freq;
      else if (speed != 16'h0000)
         speed <= speed - 16'h0001; // slow coast
   end
endmodule // mss_motor_model

// [dv/mss_seq_sva.sv]
`timescale 1ns/1ps
// port-level checks on the start/stop sequencer
module mss_seq_sva #(
   parameter TICK_CYC  = 4,
   parameter RATED_CUR = 16'h03E8
) (
   input wire        clk,
   input wire        sys_rst,
   input wire [3:0]  reg_addr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   input wire [15:0] out_freq,
   input wire        out_enable,
   input wire        dc_brake_on,
   input wire [15:0] dc_brake_cur,
   input wire        sc_brake_on,
   input wire        running,
   input wire        sleeping
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // read data only in the slot after a read strobe
   a_rdata_one_slot: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 4'hD |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // motor stage outputs follow the active phase
   a_idle_no_freq: assert property (!out_enable |-> out_freq == 16'h0000)
      else $error("frequency while output off");
   a_brakes_apart: assert property (!(dc_brake_on && sc_brake_on))
      else $error("both brake kinds at once");
   a_dc_no_drive: assert property (dc_brake_on |-> !out_enable && out_freq == 16'h0000)
      else $error("drive during dc braking");
   a_sc_no_drive: assert property (sc_brake_on |-> !out_enable)
      else $error("drive during short-circuit braking");
   a_dc_cur_scale: assert property (dc_brake_on |-> dc_brake_cur <= RATED_CUR)
      else $error("braking current above rated");
   a_phase_running: assert property (out_enable || dc_brake_on || sc_brake_on |-> running)
      else $error("active phase without running");
   a_sleep_parked: assert property (sleeping |-> !running && !out_enable)
      else $error("sleep while driving");
endmodule // mss_seq_sva

bind mss_seq mss_seq_sva #(.TICK_CYC(TICK_CYC), .RATED_CUR(RATED_CUR)) u_mss_seq_sva (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .out_freq(out_freq), .out_enable(out_enable), .dc_brake_on(dc_brake_on), .dc_brake_cur(dc_brake_cur),
   .sc_brake_on(sc_brake_on), .running(running), .sleeping(sleeping));

// [rtl/mss_consts.vh]
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH
// register offsets (word index on the register port)
`define MSS_A_CTRL        4'h0
`define MSS_A_INIT_FREQ   4'h1
`define MSS_A_HOLD_TIME   4'h2
`define MSS_A_BRK_CUR     4'h3
`define MSS_A_BRK_TIME    4'h4
`define MSS_A_START_DLY   4'h5
`define MSS_A_SC_HOLD     4'h6
`define MSS_A_STOP_SPEED  4'h7
`define MSS_A_BELOW_ACT   4'h8
`define MSS_A_LOWER_LIM   4'h9
`define MSS_A_SET_FREQ    4'hA
`define MSS_A_RAMP_STEP   4'hB
`define MSS_A_STATUS      4'hC
`define MSS_A_OUT_FREQ    4'hD
// control register fields
`define MSS_B_START_MODE  0
`define MSS_B_STOP_MODE   1
`define MSS_B_RUN         2
// reset values (frequency 0.01 Hz, time 0.01 s / 0.1 s, current 0.1 %)
`define MSS_RST_INIT_FREQ  16'h0032
`define MSS_RST_STOP_SPEED 16'h0032
`define MSS_RST_BELOW_ACT  8'h00
`define MSS_RST_RAMP_STEP  16'h0001
`define MSS_MAX_INIT_FREQ  16'h1388
`define MSS_MAX_STOP_SPEED 16'h2710
`define MSS_MAX_HOLD_01S   16'h01F4
`define MSS_MAX_BRK_001S   16'h1388
`define MSS_MAX_DLY_01S    16'h1770
`define MSS_MAX_BRK_CUR    16'h03E8
// timing: one time tick is 10 ms at the 40 MHz clock
`define MSS_TICK_NS        10000000
`define MSS_CLK_NS         25
`define MSS_TICK_CYC       (`MSS_TICK_NS / `MSS_CLK_NS)
`endif

// [rtl/mss_seq.v]
// Overview of operation
// - start mode 0 gives direct start, 1 gives DC braking before start
// - direct start without braking time drives at the initial start frequency
// - initial start frequency defaults 0.50 Hz, range 0.00 to 50.00 Hz
// - unless DC braked, output holds initial frequency for hold time, then ramps to set frequency
// - set frequency below initial start frequency keeps the drive in standby
// - lower frequency limit never clamps the initial start frequency
// - braked start applies DC current for braking time, then accelerates
// - zero pre-start braking time disables pre-start DC braking
// - braking current is a percentage of rated output current
// - after run command wait the start delay in standby before output
// - stop mode 0 decelerates, 1 coasts
// - decelerating stop ramps down and stops at the stop speed
// - coasting stop cuts output at once
// - set frequency falling below lower limit in the ramp phase triggers the below-limit action
// - below-limit action 0x00..0x12: ones run/stop/sleep, tens coast/decel
// - stop speed defaults 0.50 Hz, range 0.00 to 100.00 Hz
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_seq #(
   parameter TICK_CYC   = `MSS_TICK_CYC,
   parameter RATED_CUR  = 16'h03E8
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   output reg  [15:0] out_freq,
   output reg         out_enable,
   output reg         dc_brake_on,
   output reg  [15:0] dc_brake_cur,
   output reg         sc_brake_on,
   output reg         running,
   output reg         sleeping
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_DELAY = 3'd1;
   localparam ST_DCBRK = 3'd2;
   localparam ST_SCBRK = 3'd3;
   localparam ST_HOLD  = 3'd4;
   localparam ST_RAMP  = 3'd5;
   localparam ST_DECEL = 3'd6;
   localparam ST_SLEEP = 3'd7;

   reg [2:0]  ctrl_r;
   reg [15:0] init_freq_r, hold_r, brk_cur_r, brk_time_r, dly_r, sc_hold_r;
   reg [15:0] stop_speed_r, lower_lim_r, set_freq_r, step_r;
   reg [7:0]  below_act_r;
   reg [2:0]  st_r, st_nxt;
   reg        above_r;
   reg        tmr_start;
   reg [15:0] tmr_ticks;
   wire       tmr_done;

   // clamp a value to its maximum
   function [15:0] lim;
      input [15:0] v;
      input [15:0] m;
      begin
         lim = (v > m) ? m : v;
      end
   endfunction

   wire run_cmd  = ctrl_r[`MSS_B_RUN];
   wire stop_req = ~run_cmd;
   wire below    = (lower_lim_r != 16'h0) && (set_freq_r < lower_lim_r);
   wire fall_blw = above_r & below;
   wire [3:0] act_ones = below_act_r[3:0];
   wire       act_dec  = below_act_r[4];
   // target frequency: run-at-limit action lifts it to the limit
   wire [15:0] target = (below && act_ones == 4'h0) ? lower_lim_r : set_freq_r;
   // braking current in 0.1 % steps of the rated output current
   wire [31:0] brk_prod   = brk_cur_r * RATED_CUR;
   wire [31:0] brk_scaled = brk_prod / 32'h000003E8;

   mss_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (tmr_start),
      .abort   (stop_req),
      .ticks   (tmr_ticks),
      .done    (tmr_done)
   );

   // register writes, limited settings clamped to their maxima, out-of-range below-limit actions ignored
   always @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r       <= 3'h0;
         init_freq_r  <= `MSS_RST_INIT_FREQ;
         hold_r       <= 16'h0;
         brk_cur_r    <= 16'h0;
         brk_time_r   <= 16'h0;
         dly_r        <= 16'h0;
         sc_hold_r    <= 16'h0;
         stop_speed_r <= `MSS_RST_STOP_SPEED;
         below_act_r  <= `MSS_RST_BELOW_ACT;
         lower_lim_r  <= 16'h0;
         set_freq_r   <= 16'h0;
         step_r       <= `MSS_RST_RAMP_STEP;
      end else if (reg_wr) begin
         case (reg_addr)
            `MSS_A_CTRL:       ctrl_r       <= reg_wdata[2:0];
            `MSS_A_INIT_FREQ:  init_freq_r  <= lim(reg_wdata, `MSS_MAX_INIT_FREQ);
            `MSS_A_HOLD_TIME:  hold_r       <= lim(reg_wdata, `MSS_MAX_HOLD_01S);
            `MSS_A_BRK_CUR:    brk_cur_r    <= lim(reg_wdata, `MSS_MAX_BRK_CUR);
            `MSS_A_BRK_TIME:   brk_time_r   <= lim(reg_wdata, `MSS_MAX_BRK_001S);
            `MSS_A_START_DLY:  dly_r        <= lim(reg_wdata, `MSS_MAX_DLY_01S);
            `MSS_A_SC_HOLD:    sc_hold_r    <= lim(reg_wdata, `MSS_MAX_HOLD_01S);
            `MSS_A_STOP_SPEED: stop_speed_r <= lim(reg_wdata, `MSS_MAX_STOP_SPEED);
            `MSS_A_BELOW_ACT: begin
               if (reg_wdata[7:4] <= 4'h1 && reg_wdata[3:0] <= 4'h2)
                  below_act_r <= reg_wdata[7:0];
            end
            `MSS_A_LOWER_LIM:  lower_lim_r  <= reg_wdata;
            `MSS_A_SET_FREQ:   set_freq_r   <= reg_wdata;
            `MSS_A_RAMP_STEP:  step_r       <= (reg_wdata == 16'h0) ? 16'h1 : reg_wdata;
            default: ;
         endcase
      end
   end

   // read data one cycle after the read strobe
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `MSS_A_CTRL:       reg_rdata <= {13'h0, ctrl_r};
            `MSS_A_INIT_FREQ:  reg_rdata <= init_freq_r;
            `MSS_A_HOLD_TIME:  reg_rdata <= hold_r;
            `MSS_A_BRK_CUR:    reg_rdata <= brk_cur_r;
            `MSS_A_BRK_TIME:   reg_rdata <= brk_time_r;
            `MSS_A_START_DLY:  reg_rdata <= dly_r;
            `MSS_A_SC_HOLD:    reg_rdata <= sc_hold_r;
            `MSS_A_STOP_SPEED: reg_rdata <= stop_speed_r;
            `MSS_A_BELOW_ACT:  reg_rdata <= {8'h0, below_act_r};
            `MSS_A_LOWER_LIM:  reg_rdata <= lower_lim_r;
            `MSS_A_SET_FREQ:   reg_rdata <= set_freq_r;
            `MSS_A_RAMP_STEP:  reg_rdata <= step_r;
            `MSS_A_STATUS:     reg_rdata <= {13'h0, st_r};
            `MSS_A_OUT_FREQ:   reg_rdata <= out_freq;
            default:           reg_rdata <= 16'h0;
         endcase
      end else begin
         reg_rdata <= 16'h0;
      end
   end

   // phase sequencing
   always @* begin
      st_nxt    = st_r;
      tmr_start = 1'b0;
      tmr_ticks = 16'h0;
      case (st_r)
         ST_IDLE: begin
            // standby while set frequency is under the initial frequency
            if (run_cmd && set_freq_r >= init_freq_r && !(below && act_ones != 4'h0)) begin
               st_nxt    = ST_DELAY;
               tmr_start = 1'b1;
               tmr_ticks = {dly_r[11:0], 4'h0} - {dly_r[13:0], 2'h0} - {dly_r[14:0], 1'b0}; // x10
            end
         end
         ST_DELAY: begin
            if (stop_req) begin
               st_nxt = ST_IDLE;
            end else if (tmr_done) begin
               tmr_start = 1'b1;
               if (ctrl_r[`MSS_B_START_MODE] && brk_time_r != 16'h0) begin
                  st_nxt    = ST_DCBRK;
                  tmr_ticks = brk_time_r;
               end else if (!ctrl_r[`MSS_B_START_MODE] && sc_hold_r != 16'h0) begin
                  st_nxt    = ST_SCBRK;
                  tmr_ticks = {sc_hold_r[12:0], 3'h0} + {sc_hold_r[14:0], 1'b0};
               end else begin
                  st_nxt    = ST_HOLD;
                  tmr_ticks = {hold_r[12:0], 3'h0} + {hold_r[14:0], 1'b0};
               end
            end
         end
         ST_DCBRK: begin
            if (stop_req) begin
               st_nxt = ST_IDLE;
            end else if (tmr_done) begin
               st_nxt = ST_RAMP;
            end
         end
         ST_SCBRK: begin
            if (stop_req) begin
               st_nxt = ST_IDLE;
            end else if (tmr_done) begin
               st_nxt    = ST_HOLD;
               tmr_start = 1'b1;
               tmr_ticks = {hold_r[12:0], 3'h0} + {hold_r[14:0], 1'b0};
            end
         end
         ST_HOLD: begin
            if (stop_req) begin
               st_nxt = ctrl_r[`MSS_B_STOP_MODE] ? ST_IDLE : ST_DECEL;
            end else if (tmr_done) begin
               st_nxt = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (stop_req) begin
               st_nxt = ctrl_r[`MSS_B_STOP_MODE] ? ST_IDLE : ST_DECEL;
            end else if (fall_blw && act_ones != 4'h0) begin
               if (act_ones == 4'h2)
                  st_nxt = act_dec ? ST_DECEL : ST_SLEEP;
               else
                  st_nxt = act_dec ? ST_DECEL : ST_IDLE;
            end
         end
         ST_DECEL: begin
            if (out_freq <= stop_speed_r) begin
               st_nxt = (below && act_ones == 4'h2 && run_cmd) ? ST_SLEEP : ST_IDLE;
            end
         end
         ST_SLEEP: begin
            if (stop_req)
               st_nxt = ST_IDLE;
            else if (!below)
               st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // state, frequency and drive outputs
   always @(posedge clk) begin
      if (sys_rst) begin
         st_r         <= ST_IDLE;
         above_r      <= 1'b0;
         out_freq     <= 16'h0;
         out_enable   <= 1'b0;
         dc_brake_on  <= 1'b0;
         dc_brake_cur <= 16'h0;
         sc_brake_on  <= 1'b0;
         running      <= 1'b0;
         sleeping     <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         above_r     <= ~below;
         dc_brake_on <= (st_nxt == ST_DCBRK);
         // current scaled against rated output current
         dc_brake_cur <= (st_nxt == ST_DCBRK) ? brk_scaled[15:0] : 16'h0;
         sc_brake_on <= (st_nxt == ST_SCBRK);
         out_enable  <= (st_nxt == ST_HOLD) || (st_nxt == ST_RAMP) || (st_nxt == ST_DECEL);
         running     <= (st_nxt != ST_IDLE) && (st_nxt != ST_SLEEP);
         sleeping    <= (st_nxt == ST_SLEEP);
         case (st_nxt)
            ST_HOLD:  out_freq <= init_freq_r;
            ST_RAMP: begin
               if (st_r != ST_RAMP && st_r != ST_HOLD)
                  out_freq <= init_freq_r;
               else if (out_freq + step_r < target)
                  out_freq <= out_freq + step_r;
               else if (out_freq > target + step_r)
                  out_freq <= out_freq - step_r;
               else
                  out_freq <= target;
            end
            ST_DECEL: out_freq <= (out_freq > step_r) ? out_freq - step_r : 16'h0;
            default:  out_freq <= 16'h0;
         endcase
      end
   end
endmodule // mss_seq

// [rtl/mss_timer.v]
`timescale 1ns/1ps
// counts down a number of time ticks; done pulses when the count ends
module mss_timer #(
   parameter TICK_CYC = 400000
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        start,
   input  wire        abort,
   input  wire [15:0] ticks,
   output reg         done
);
   reg [31:0] pre_r;
   reg [15:0] cnt_r;
   reg        busy_r;

   // prescaler and tick counter
   always @(posedge clk) begin
      if (sys_rst) begin
         pre_r  <= 32'h0;
         cnt_r  <= 16'h0;
         busy_r <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy_r <= 1'b0;
         end else if (start) begin
            pre_r  <= 32'h0;
            cnt_r  <= ticks;
            busy_r <= (ticks != 16'h0);
            done   <= (ticks == 16'h0);
         end else if (busy_r) begin
            if (pre_r == TICK_CYC - 1) begin
               pre_r <= 32'h0;
               if (cnt_r == 16'h1) begin
                  busy_r <= 1'b0;
                  done   <= 1'b1;
               end
               cnt_r <= cnt_r - 16'h1;
            end else begin
               pre_r <= pre_r + 32'h1;
            end
         end
      end
   end
endmodule // mss_timer
